// *** design/aka_pkg.sv ***
// constants shared by the admin keep-alive / attach engine and its memory
// assumes a 200 MHz aclk and a 32-bit AXI4-Lite register bus
package aka_pkg;
	// ************************************************
	// timing
	// ************************************************
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned KA_GRAN_MS = 100; // one keep-alive tick in ms
	localparam int unsigned KA_TICK_CYCLES = KA_GRAN_MS * 1000 * CLK_MHZ;
	localparam logic [7:0] KA_GRAN_FIELD = 8'h01; // granularity in 100 ms units
	// ************************************************
	// register byte offsets
	// ************************************************
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_CDW10 = 8'h04;
	localparam logic [7:0] OFS_NSID = 8'h08;
	localparam logic [7:0] OFS_PTR_LO = 8'h0C;
	localparam logic [7:0] OFS_PTR_HI = 8'h10;
	localparam logic [7:0] OFS_CQE = 8'h14;
	localparam logic [7:0] OFS_ERR_OFS = 8'h18;
	localparam logic [7:0] OFS_KA_CFG = 8'h1C;
	localparam logic [7:0] OFS_IDCTRL = 8'h20;
	localparam logic [7:0] OFS_ASSOC = 8'h24;
	localparam logic [7:0] OFS_UUID0 = 8'h28; // unique_identifier bits 31:0, up to 0x34 for 127:96
	localparam logic [7:0] OFS_IRQ_ST = 8'h38;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h3C;
	localparam logic [2:0] OFS_ENTRY_TOP = 3'b010; // 0x40..0x5C identifier entry dwords
	localparam logic [7:0] OFS_ATT_MAP = 8'h60;
	localparam logic [7:0] OFS_NS_PRIV = 8'h64;
	localparam logic [7:0] OFS_ANA_BLK = 8'h68;
	// ************************************************
	// fields
	// ************************************************
	localparam int unsigned KA_TBKA_BIT = 16;
	localparam int unsigned IDC_NSMGMT_BIT = 8;
	localparam int unsigned IDC_ATTACH_BIT = 9;
	localparam int unsigned CQE_BUSY_BIT = 16;
	localparam int unsigned CQE_PHASE_BIT = 17;
	localparam int unsigned IRQ_DONE_BIT = 0;
	localparam int unsigned IRQ_KATO_BIT = 1;
	localparam logic [1:0] ASSOC_NONE = 2'b00;
	localparam logic [1:0] ASSOC_VENDOR = 2'b01;
	localparam logic [1:0] ASSOC_SUBSYS = 2'b10;
	localparam logic [3:0] SEL_ATTACH = 4'h0;
	localparam logic [3:0] SEL_DETACH = 4'h1;
	localparam logic [9:0] LIST_LAST_DW = 10'h3FF; // 4096-byte list is 1024 dwords
	localparam logic [15:0] LIST_MAX_IDS = 16'h07FF;
	// ************************************************
	// opcodes and status codes
	// ************************************************
	localparam logic [7:0] OP_IDENTIFY = 8'h06;
	localparam logic [7:0] OP_NS_MGMT = 8'h0D;
	localparam logic [7:0] OP_NS_ATTACH = 8'h15;
	localparam logic [7:0] OP_KEEPALIVE = 8'h18;
	localparam logic [7:0] SC_SUCCESS = 8'h00;
	localparam logic [7:0] SC_INV_OPCODE = 8'h01;
	localparam logic [7:0] SC_INV_FIELD = 8'h02;
	localparam logic [7:0] SC_INV_NS = 8'h0B;
	localparam logic [7:0] SC_ALREADY = 8'h18;
	localparam logic [7:0] SC_PRIVATE = 8'h19;
	localparam logic [7:0] SC_NOT_ATT = 8'h1A;
	localparam logic [7:0] SC_LIST_INV = 8'h1C;
	localparam logic [7:0] SC_ANA = 8'h25;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// *** design/aka_att_mem.sv ***
// attachment map store: one word of controller bits per namespace
// assumes a single clock; no reset so the map outlives every reset
`timescale 1ns/1ps
module aka_att_mem import aka_pkg::*; #(
	parameter int unsigned DEPTH = 8,
	parameter int unsigned WIDTH = 16
) (
	input wire logic clk, // engine clock
	input wire logic we, // write strobe
	input wire logic [$clog2(DEPTH)-1:0] addr, // namespace index
	input wire logic [WIDTH-1:0] wdata, // new map word
	output logic [WIDTH-1:0] rdata // registered read word
);
	logic [WIDTH-1:0] mem [DEPTH];
	// ************************************************
	// storage, deliberately outside any reset
	// ************************************************
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule

// *** design/aka_admin_engine.sv ***
// admin command engine: identifier entry, keep-alive timer, namespace attach
// assumes AXI4-Lite master on aclk and a dword fetch port into host memory
// Functional notes
// - association code none, vendor, subsystem; 11 reserved
// - unique_identifier in entry bytes 31:16, big-endian
// - identify finish posts a completion
// - report keep-alive tick granularity in id data
// - keep-alive command restarts timer when enabled
// - traffic-based: restart at expiry after activity
// - keep-alive completion carries its status
// - attach state survives every reset
// - attach support implies namespace management support
// - attach uses only namespace id, pointer and dword 10
// - fetch the whole 4096-byte controller list
// - act on exactly the listed controllers
// - dword10 bits 3:0 select attach or detach
// - stop at first bad entry, log offset
// - distinct status codes per failure case
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module aka_admin_engine import aka_pkg::*; #(
	parameter int unsigned NS_COUNT = 8,
	parameter int unsigned NUM_CTRL = 16,
	parameter int unsigned KA_TICKS = KA_TICK_CYCLES
) (
	input wire logic aclk, // 200 MHz clock
	input wire logic aresetn, // sync reset, low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output logic fetch_req, // list dword request, held until answered
	output logic [63:0] fetch_addr, // host byte address of dword
	input wire logic fetch_valid, // dword returned
	input wire logic [31:0] fetch_data, // returned dword
	input wire logic io_cmd_done, // pulse per processed i/o command
	output logic irq // level interrupt
);
	localparam int unsigned NSW = $clog2(NS_COUNT);
	localparam int unsigned CW = $clog2(NUM_CTRL);
	typedef enum logic [2:0] {S_IDLE, S_RD, S_RDW, S_FETCH, S_E0, S_E1, S_WR, S_DONE} aka_st_e;

	aka_st_e st_q, st_d;
	logic aw_have_q, aw_have_d, w_have_q, w_have_d, awready_q, awready_d, wready_q, wready_d;
	logic [7:0] aw_addr_q, aw_addr_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0] w_strb_q, w_strb_d;
	logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d, cdw10_q, cdw10_d, nsid_q, nsid_d, err_ofs_q, err_ofs_d;
	logic [63:0] ptr_q, ptr_d, faddr_q, faddr_d;
	logic [127:0] unique_identifier_q, unique_identifier_d;
	logic [255:0] entry_q, entry_d;
	logic [1:0] assoc_q, assoc_d, irq_st_q, irq_st_d, irq_mask_q, irq_mask_d;
	logic [7:0] op_q, op_d, sc_q, sc_d;
	logic phase_q, phase_d, err_q, err_d, irq_q, irq_d, freq_q, freq_d;
	logic [15:0] kato_q, kato_d, ka_cnt_q, ka_cnt_d, count_q, count_d;
	logic tbka_q, tbka_d, ka_run_q, ka_run_d, act_q, act_d;
	logic [31:0] div_q, div_d;
	logic [9:0] dw_q, dw_d;
	logic [31:0] dword_q, dword_d;
	logic [NUM_CTRL-1:0] map_q, map_d, ana_q, ana_d;
	logic [NS_COUNT-1:0] priv_q, priv_d;
	logic [NUM_CTRL-1:0] mem_rdata;
	logic mem_we;
	logic wr_fire, rd_fire, launch, tick, expire;
	logic [10:0] pos;
	logic [15:0] cid;
	logic [NSW-1:0] ns_idx;

	// apply byte strobes to one register word
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// ************************************************
	// persistent attachment store
	// ************************************************
	aka_att_mem #(.DEPTH(NS_COUNT), .WIDTH(NUM_CTRL)) u_mem (
		.clk(aclk),
		.we(mem_we),
		.addr(ns_idx),
		.wdata(map_q),
		.rdata(mem_rdata)
	);

	// shared decode terms
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	assign rd_fire = s_axi_arvalid && arready_q;
	assign launch = wr_fire && aw_addr_q == OFS_CMD && st_q == S_IDLE;
	assign tick = div_q == 32'(KA_TICKS - 1);
	assign expire = tick && ka_run_q && (ka_cnt_q + 16'h0001) >= kato_q;
	assign ns_idx = NSW'(nsid_q - 32'h0000_0001);
	assign pos = {dw_q, st_q == S_E1};
	assign cid = (st_q == S_E1) ? dword_q[31:16] : dword_q[15:0];
	assign mem_we = st_q == S_WR; // map written back once per attach command that fetches the list

	// ************************************************
	// next-state logic for bus, engine and timer
	// ************************************************
	always_comb begin
		st_d = st_q;
		{aw_have_d, w_have_d, aw_addr_d, w_data_d, w_strb_d} =
			{aw_have_q, w_have_q, aw_addr_q, w_data_q, w_strb_q};
		{bvalid_d, bresp_d, rvalid_d, rresp_d, rdata_d} = {bvalid_q, bresp_q, rvalid_q, rresp_q, rdata_q};
		{cdw10_d, nsid_d, ptr_d, unique_identifier_d, assoc_d, entry_d} = {cdw10_q, nsid_q, ptr_q, unique_identifier_q, assoc_q, entry_q};
		{irq_mask_d, op_d, sc_d, phase_d, err_d, err_ofs_d, freq_d} =
			{irq_mask_q, op_q, sc_q, phase_q, err_q, err_ofs_q, freq_q};
		{kato_d, tbka_d, ka_cnt_d, ka_run_d, dw_d, dword_d, count_d} =
			{kato_q, tbka_q, ka_cnt_q, ka_run_q, dw_q, dword_q, count_q};
		{map_d, ana_d, priv_d} = {map_q, ana_q, priv_q};
		irq_st_d = irq_st_q;
		act_d = act_q;
		div_d = tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
		// bus channel capture
		if (s_axi_awvalid && awready_q) begin
			aw_have_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_have_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		// keep-alive timer; expiry ends the interval and clears activity
		if (expire) begin
			ka_cnt_d = 16'h0000;
			act_d = 1'b0;
			if (tbka_q && act_q) begin
				ka_run_d = 1'b1;
			end else begin
				ka_run_d = 1'b0;
				irq_st_d[IRQ_KATO_BIT] = 1'b1;
			end
		end else if (tick && ka_run_q) begin
			ka_cnt_d = ka_cnt_q + 16'h0001;
		end
		// register write; cmd launches only when idle
		if (wr_fire) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			case (aw_addr_q)
				OFS_CMD: ;
				OFS_CDW10: cdw10_d = wmerge(cdw10_q, w_data_q, w_strb_q);
				OFS_NSID: nsid_d = wmerge(nsid_q, w_data_q, w_strb_q);
				OFS_PTR_LO: ptr_d[31:0] = wmerge(ptr_q[31:0], w_data_q, w_strb_q);
				OFS_PTR_HI: ptr_d[63:32] = wmerge(ptr_q[63:32], w_data_q, w_strb_q);
				OFS_KA_CFG: begin
					{tbka_d, kato_d} = {w_data_q[KA_TBKA_BIT], w_data_q[15:0]};
					ka_cnt_d = 16'h0000;
					ka_run_d = w_data_q[15:0] != 16'h0000;
				end
				OFS_ASSOC: begin
					// reserved code 11b falls back to no association
					assoc_d = (w_data_q[1:0] == 2'b11) ? ASSOC_NONE : w_data_q[1:0];
				end
				OFS_UUID0, OFS_UUID0 + 8'h04, OFS_UUID0 + 8'h08, OFS_UUID0 + 8'h0C:
					unique_identifier_d[{aw_addr_q[3:2] - 2'b10, 5'b0} +: 32] = w_data_q;
				OFS_IRQ_ST: irq_st_d = irq_st_q & ~w_data_q[1:0];
				OFS_IRQ_MASK: irq_mask_d = w_data_q[1:0];
				OFS_NS_PRIV: priv_d = w_data_q[NS_COUNT-1:0];
				OFS_ANA_BLK: ana_d = w_data_q[NUM_CTRL-1:0];
				default: bresp_d = RESP_SLVERR;
			endcase
		end
		// register read
		if (rd_fire) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			rdata_d = 32'h0000_0000;
			if (s_axi_araddr[7:5] == OFS_ENTRY_TOP) begin
				rdata_d = entry_q[{s_axi_araddr[4:2], 5'b0} +: 32];
			end else begin
				case (s_axi_araddr)
					OFS_CMD: rdata_d = {24'h00_0000, op_q};
					OFS_CDW10: rdata_d = cdw10_q;
					OFS_NSID: rdata_d = nsid_q;
					OFS_PTR_LO: rdata_d = ptr_q[31:0];
					OFS_PTR_HI: rdata_d = ptr_q[63:32];
					OFS_CQE: rdata_d = {14'h0000, phase_q, st_q != S_IDLE, op_q, sc_q};
					OFS_ERR_OFS: rdata_d = err_ofs_q;
					OFS_KA_CFG: rdata_d = {15'h0000, tbka_q, kato_q};
					OFS_IDCTRL: begin
						// namespace management is accepted whenever attach is
						rdata_d = {22'h00_0000, 2'b11, KA_GRAN_FIELD};
					end
					OFS_ASSOC: rdata_d = {30'h0000_0000, assoc_q};
					OFS_UUID0, OFS_UUID0 + 8'h04, OFS_UUID0 + 8'h08, OFS_UUID0 + 8'h0C:
						rdata_d = unique_identifier_q[{s_axi_araddr[3:2] - 2'b10, 5'b0} +: 32];
					OFS_IRQ_ST: rdata_d = {30'h0000_0000, irq_st_q};
					OFS_IRQ_MASK: rdata_d = {30'h0000_0000, irq_mask_q};
					OFS_ATT_MAP: rdata_d = 32'(map_q);
					OFS_NS_PRIV: rdata_d = 32'(priv_q);
					OFS_ANA_BLK: rdata_d = 32'(ana_q);
					default: rresp_d = RESP_SLVERR;
				endcase
			end
		end
		// command engine
		case (st_q)
			S_IDLE: begin
				if (launch) begin
					op_d = w_data_q[7:0];
					sc_d = SC_SUCCESS;
					err_d = 1'b0;
					st_d = S_DONE;
					case (w_data_q[7:0])
						OP_IDENTIFY: begin
							entry_d = 256'(assoc_q);
							for (int i = 0; i < 16; i++) begin
								entry_d[(16 + i) * 8 +: 8] = unique_identifier_q[127 - 8 * i -: 8];
							end
						end
						OP_KEEPALIVE: begin
							// no command fields are read for keep-alive
							ka_cnt_d = 16'h0000;
							ka_run_d = kato_q != 16'h0000;
						end
						OP_NS_MGMT: ;
						OP_NS_ATTACH: begin
							// only the namespace id, the pointer and the dword 10 select bits matter
							if (cdw10_q[3:0] != SEL_ATTACH && cdw10_q[3:0] != SEL_DETACH) begin
								sc_d = SC_INV_FIELD;
							end else if (nsid_q == 32'h0000_0000 || nsid_q > 32'(NS_COUNT)) begin
								sc_d = SC_INV_NS;
							end else begin
								st_d = S_RD;
								dw_d = 10'h000;
							end
						end
						default: sc_d = SC_INV_OPCODE;
					endcase
				end
			end
			S_RD: st_d = S_RDW;
			S_RDW: begin
				map_d = mem_rdata;
				st_d = S_FETCH;
				freq_d = 1'b1;
			end
			S_FETCH: begin
				if (freq_q && fetch_valid) begin
					freq_d = 1'b0;
					dword_d = fetch_data;
					st_d = S_E0;
				end
			end
			S_E0, S_E1: begin
				// list entries after the first failure are fetched but ignored
				if (pos == 11'h000) begin
					count_d = cid;
					if (cid > LIST_MAX_IDS) begin
						{err_d, sc_d, err_ofs_d} = {1'b1, SC_LIST_INV, 32'h0000_0000};
					end
				end else if (!err_q && 16'(pos) <= count_q) begin
					err_ofs_d = {20'h0_0000, pos, 1'b0};
					err_d = 1'b1;
					if (cid >= 16'(NUM_CTRL)) begin
						sc_d = SC_LIST_INV;
					end else if (cdw10_q[3:0] == SEL_ATTACH) begin
						if (map_q[cid[CW-1:0]]) begin
							sc_d = SC_ALREADY;
						end else if (priv_q[ns_idx] && map_q != '0) begin
							sc_d = SC_PRIVATE;
						end else if (ana_q[cid[CW-1:0]]) begin
							sc_d = SC_ANA;
						end else begin
							{err_d, err_ofs_d} = {1'b0, err_ofs_q};
							map_d[cid[CW-1:0]] = 1'b1;
						end
					end else if (!map_q[cid[CW-1:0]]) begin
						sc_d = SC_NOT_ATT;
					end else begin
						{err_d, err_ofs_d} = {1'b0, err_ofs_q};
						map_d[cid[CW-1:0]] = 1'b0;
					end
				end
				if (st_q == S_E0) begin
					st_d = S_E1;
				end else if (dw_q == LIST_LAST_DW) begin
					st_d = S_WR;
				end else begin
					dw_d = dw_q + 10'h001;
					st_d = S_FETCH;
					freq_d = 1'b1;
				end
			end
			S_WR: st_d = S_DONE;
			S_DONE: begin
				// every command, identify and keep-alive included, completes here
				phase_d = ~phase_q;
				irq_st_d[IRQ_DONE_BIT] = 1'b1;
				st_d = S_IDLE;
			end
			default: st_d = S_IDLE;
		endcase
		// events set after any clear in the same cycle
		if (launch || io_cmd_done) begin
			act_d = 1'b1;
		end
		if (expire && !(tbka_q && act_q)) begin
			irq_st_d[IRQ_KATO_BIT] = 1'b1;
		end
		if (st_q == S_DONE) begin
			irq_st_d[IRQ_DONE_BIT] = 1'b1;
		end
		awready_d = !aw_have_d && !bvalid_d;
		wready_d = !w_have_d && !bvalid_d;
		arready_d = !rvalid_d;
		irq_d = (irq_st_d & irq_mask_d) != 2'b00;
		// address moves with the dword index, so it is steady while a fetch is asked
		faddr_d = ptr_d + {52'h0_0000_0000_0000, dw_d, 2'b00};
	end

	// ************************************************
	// state registers; attach map store is not reset here
	// ************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= S_IDLE;
			{aw_have_q, w_have_q, aw_addr_q, w_data_q, w_strb_q} <= '0;
			{awready_q, wready_q, arready_q} <= '0;
			{bvalid_q, bresp_q, rvalid_q, rresp_q, rdata_q} <= '0;
			{cdw10_q, nsid_q, ptr_q, unique_identifier_q, assoc_q, entry_q} <= '0;
			{irq_st_q, irq_mask_q, op_q, sc_q, phase_q, err_q, err_ofs_q, freq_q, irq_q} <= '0;
			{kato_q, tbka_q, ka_cnt_q, ka_run_q, act_q, div_q} <= '0;
			{dw_q, dword_q, count_q, map_q, ana_q, priv_q} <= '0;
			faddr_q <= '0;
		end else begin
			st_q <= st_d;
			{aw_have_q, w_have_q, aw_addr_q, w_data_q, w_strb_q} <=
				{aw_have_d, w_have_d, aw_addr_d, w_data_d, w_strb_d};
			{awready_q, wready_q, arready_q} <= {awready_d, wready_d, arready_d};
			{bvalid_q, bresp_q, rvalid_q, rresp_q, rdata_q} <= {bvalid_d, bresp_d, rvalid_d, rresp_d, rdata_d};
			{cdw10_q, nsid_q, ptr_q, unique_identifier_q, assoc_q, entry_q} <=
				{cdw10_d, nsid_d, ptr_d, unique_identifier_d, assoc_d, entry_d};
			{irq_st_q, irq_mask_q, op_q, sc_q, phase_q, err_q, err_ofs_q, freq_q, irq_q} <=
				{irq_st_d, irq_mask_d, op_d, sc_d, phase_d, err_d, err_ofs_d, freq_d, irq_d};
			{kato_q, tbka_q, ka_cnt_q, ka_run_q, act_q, div_q} <=
				{kato_d, tbka_d, ka_cnt_d, ka_run_d, act_d, div_d};
			{dw_q, dword_q, count_q, map_q, ana_q, priv_q} <= {dw_d, dword_d, count_d, map_d, ana_d, priv_d};
			faddr_q <= faddr_d;
		end
	end

	// outputs straight from flops
	assign {s_axi_awready, s_axi_wready, s_axi_arready} = {awready_q, wready_q, arready_q};
	assign {s_axi_bvalid, s_axi_bresp, s_axi_rvalid, s_axi_rresp, s_axi_rdata} =
		{bvalid_q, bresp_q, rvalid_q, rresp_q, rdata_q};
	assign fetch_req = freq_q;
	assign fetch_addr = faddr_q;
	assign irq = irq_q;

	// ************************************************
	// assertions
	// ************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_launch_op(logic [7:0] op);
		launch && w_data_q[7:0] == op;
	endsequence
	a_assoc_code: assert property (entry_q[7:2] == 6'h00 && entry_q[127:8] == '0
		&& entry_q[1:0] != 2'b11) else $error("entry header malformed");
	a_unique_identifier_place: assert property (s_launch_op(OP_IDENTIFY) |=> entry_q[135:128] == $past(unique_identifier_q[127:120])
		&& entry_q[255:248] == $past(unique_identifier_q[7:0])) else $error("unique_identifier bytes misplaced");
	a_identify_done: assert property (s_launch_op(OP_IDENTIFY) |=> st_q == S_DONE ##1
		(phase_q != $past(phase_q) && irq_st_q[IRQ_DONE_BIT])) else $error("identify no completion");
	a_gran_report: assert property (rd_fire && s_axi_araddr == OFS_IDCTRL |=>
		rdata_q[7:0] == KA_GRAN_FIELD && rdata_q[IDC_ATTACH_BIT]) else $error("bad id data");
	a_ka_restart: assert property (s_launch_op(OP_KEEPALIVE) ##0 kato_q != 16'h0000 |=>
		ka_cnt_q == 16'h0000 && ka_run_q) else $error("keep-alive no restart");
	a_traffic_restart: assert property (expire && tbka_q && act_q |=> ka_run_q && ka_cnt_q == 16'h0000
		&& irq_st_q[IRQ_KATO_BIT] == $past(irq_st_q[IRQ_KATO_BIT])) else $error("tbka no restart");
	a_ka_complete: assert property (s_launch_op(OP_KEEPALIVE) |=> ##1 sc_q == SC_SUCCESS
		&& irq_st_q[IRQ_DONE_BIT]) else $error("keep-alive no completion");
	a_bad_select: assert property (s_launch_op(OP_NS_ATTACH) ##0 cdw10_q[3:0] > SEL_DETACH |=>
		st_q == S_DONE && sc_q == SC_INV_FIELD && !mem_we) else $error("reserved select");
	a_full_fetch: assert property (st_q == S_WR |-> dw_q == LIST_LAST_DW && $past(st_q) == S_E1)
		else $error("list cut short");
	a_err_offset: assert property ($rose(err_q) && $past(pos) != 11'h000 |->
		err_ofs_q == {20'h0_0000, $past(pos), 1'b0}) else $error("bad error offset");
	a_stop_on_err: assert property (err_q && (st_q == S_E0 || st_q == S_E1) |=>
		map_q == $past(map_q) && sc_q == $past(sc_q)) else $error("processed past error");
endmodule

// *** verification/aka_host_mem.sv ***
// host memory model that answers the engine's controller-list fetches
// assumes list buffers sit on 4096-byte boundaries; index is address bits 11:2
`timescale 1ns/1ps
module aka_host_mem (
	input wire logic aclk, // engine clock
	input wire logic slow, // answer only after a few idle cycles
	input wire logic fetch_req, // dword request from the engine
	input wire logic [63:0] fetch_addr, // host byte address
	output logic fetch_valid = 1'b0, // one-cycle answer
	output logic [31:0] fetch_data = 32'h0000_0000 // answer word
);
	logic [31:0] mem [0:1023];
	int gap = 0;
	// one answer per request; data flips outside the answer cycle so stale
	// words are never mistaken for fresh ones
	always @(posedge aclk) begin
		fetch_valid <= 1'b0;
		fetch_data <= ~fetch_data;
		if (fetch_req && !fetch_valid) begin
			if (gap >= (slow ? 4 : 0)) begin
				fetch_valid <= 1'b1;
				fetch_data <= mem[fetch_addr[11:2]];
				gap <= 0;
			end else begin
				gap <= gap + 1;
			end
		end
	end
endmodule

// *** verification/admin_keepalive_ns_attach_tb_top.sv ***
// bench for the admin engine: AXI4-Lite tasks, command sequences, checks
// assumes aka_pkg, the engine and the host memory model; timer tick cut to 8
`timescale 1ns/1ps
module admin_keepalive_ns_attach_tb_top import aka_pkg::*;;
	logic aclk = 1'b0, aresetn = 1'b0, io_cmd_done = 1'b0, slow = 1'b0, ph = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, fetch_data;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, lb;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic fetch_req, fetch_valid, irq;
	logic [63:0] fetch_addr;
	int mismatches = 0, tests_run = 0, nf = 0;
	aka_admin_engine #(.KA_TICKS(8)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fetch_req, .fetch_addr,
		.fetch_valid, .fetch_data, .io_cmd_done, .irq);
	aka_host_mem host (.aclk, .slow, .fetch_req, .fetch_addr, .fetch_valid, .fetch_data);
	// 200 MHz clock and a count of list dwords taken
	initial begin
		forever #2.5 aclk = ~aclk;
	end
	always @(posedge aclk) if (fetch_req && fetch_valid) nf++;
	// watchdog well beyond the longest expected run
	initial begin
		#450_000;
		mismatches++;
		report_and_stop();
	end
	// ************************************************
	// tasks
	// ************************************************
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		lb = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// launch, poll until not busy, then check phase, opcode and status
	task automatic cmd(input logic [7:0] op, input logic [7:0] sc);
		logic [31:0] v;
		logic [1:0] r;
		wr(OFS_CMD, {24'h0, op});
		do rd(OFS_CQE, v, r); while (v[CQE_BUSY_BIT] !== 1'b0);
		ph = ~ph;
		chk("completion", v & 32'h0003_FFFF, {14'h0, ph, 1'b0, op, sc});
	endtask
	task automatic att(input logic [3:0] sel, input logic [15:0] cnt, input logic [31:0] ids,
		input logic [7:0] sc);
		// first id shares dword 0 with the count, the second opens dword 1
		host.mem[0] = {ids[15:0], cnt};
		host.mem[1] = {16'h0, ids[31:16]};
		nf = 0;
		slow <= ~slow;
		wr(OFS_CDW10, {28'h0, sel});
		cmd(OP_NS_ATTACH, sc);
	endtask
	task automatic report_and_stop();
		if (mismatches == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ************************************************
	// tests
	// ************************************************
	initial begin
		logic [31:0] v;
		logic [1:0] r;
		for (int i = 2; i < 1024; i++) host.mem[i] = 32'hA5A5_0000 ^ 32'(i);
		// the store has no reset, so a factory-blank part is preset here
		for (int i = 0; i < 8; i++) dut.u_mem.mem[i] = 16'h0000;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFS_IDCTRL, v, r);
		chk("idctrl", v, {22'h0, 2'b11, KA_GRAN_FIELD});
		rd(8'hFC, v, r);
		chk("unmapped", {30'h0, r}, {30'h0, RESP_SLVERR});
		wr(8'hFC, 32'h0000_0000);
		chk("wr unmapped", {30'h0, lb}, {30'h0, RESP_SLVERR});
		for (int i = 0; i < 4; i++) wr(OFS_UUID0 + 8'(4 * i), 32'h1122_3340 + 32'(i));
		// every association code, the reserved one reads back as none
		for (int a = 0; a < 4; a++) begin
			wr(OFS_ASSOC, 32'(a));
			cmd(OP_IDENTIFY, SC_SUCCESS);
			rd(8'h40, v, r);
			chk("assoc", v & 32'h0000_FFFF, (a == 3) ? 32'h0 : 32'(a));
		end
		for (int i = 0; i < 4; i++) begin
			rd(8'h50 + 8'(4 * i), v, r);
			chk("unique_identifier", v, {8'h40 + 8'(3 - i), 24'h33_2211});
		end
		chk("irq masked", {31'h0, irq}, 32'h0);
		wr(OFS_IRQ_MASK, 32'h0000_0003);
		chk("wr okay", {30'h0, lb}, {30'h0, RESP_OKAY});
		chk("irq on", {31'h0, irq}, 32'h1);
		wr(OFS_IRQ_ST, 32'h0000_0001);
		chk("irq clear", {31'h0, irq}, 32'h0);
		// keep-alive commands hold off a four-tick timeout
		wr(OFS_KA_CFG, 32'h0000_0004);
		repeat (5) cmd(OP_KEEPALIVE, SC_SUCCESS);
		rd(OFS_IRQ_ST, v, r);
		chk("ka alive", v & 32'h2, 32'h0);
		repeat (60) @(posedge aclk);
		rd(OFS_IRQ_ST, v, r);
		chk("ka expired", v & 32'h2, 32'h2);
		// traffic-based: i/o activity alone keeps the timer alive
		wr(OFS_IRQ_ST, 32'h0000_0003);
		wr(OFS_KA_CFG, 32'h0001_0002);
		repeat (30) begin
			@(posedge aclk) io_cmd_done <= 1'b1;
			@(posedge aclk) io_cmd_done <= 1'b0;
			repeat (3) @(posedge aclk);
		end
		rd(OFS_IRQ_ST, v, r);
		chk("tbka alive", v & 32'h2, 32'h0);
		repeat (60) @(posedge aclk);
		rd(OFS_IRQ_ST, v, r);
		chk("tbka expired", v & 32'h2, 32'h2);
		// attach, then failures that stop part way through the list or, for reserved selects, before any fetch
		wr(OFS_NSID, 32'h0000_0001);
		wr(OFS_PTR_LO, 32'h0000_1000);
		att(SEL_ATTACH, 16'h2, 32'h0005_0003, SC_SUCCESS);
		chk("fetched", 32'(nf), 32'd1024);
		rd(OFS_ATT_MAP, v, r);
		chk("map", v, 32'h0000_0028);
		att(SEL_ATTACH, 16'h2, 32'h0003_0007, SC_ALREADY);
		rd(OFS_ERR_OFS, v, r);
		chk("err ofs", v, 32'h4);
		rd(OFS_ATT_MAP, v, r);
		chk("map", v, 32'h0000_00A8);
		att(SEL_DETACH, 16'h1, 32'h0000_0009, SC_NOT_ATT);
		att(SEL_ATTACH, 16'h1, 32'h0000_0010, SC_LIST_INV);
		att(SEL_ATTACH, 16'h0800, 32'h0000_0001, SC_LIST_INV);
		rd(OFS_ERR_OFS, v, r);
		chk("err ofs", v, 32'h0);
		for (int s = 2; s < 16; s++) att(4'(s), 16'h1, 32'h0000_0002, SC_INV_FIELD);
		// attachments outlive a reset: detach of 3 must succeed
		@(posedge aclk) aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		ph = 1'b0;
		wr(OFS_NSID, 32'h0000_0001);
		wr(OFS_PTR_LO, 32'h0000_1000);
		att(SEL_DETACH, 16'h1, 32'h0000_0003, SC_SUCCESS);
		rd(OFS_ATT_MAP, v, r);
		chk("map", v, 32'h0000_00A0);
		report_and_stop();
	end
endmodule
